// *** verilog/sm_pkg.sv ***
// constants of the signal modulator control block
// assumes a single 100 MHz clock and an AXI4-Lite master for software access
// Operation
// - sleep leaves the modulator running unchanged
// - mixing continues in sleep if sources run
// - any reset disables the modulator
// - reset restores defaults; slew bit one, others zero
// - bits two and one read zero
// - bit zero is the software modulator value
// - software bit high mixes high carrier
// - disable grounds carriers, uses software bit
// - output enable clear holds pin low
// - invert bit inverts the modulated output
package sm_pkg;
    localparam logic [31:0] SM_CTRL_ADDR = 32'h0000_0000;
    localparam int SM_ENABLE_POS = 7;
    localparam int SM_OE_POS = 6;
    localparam int SM_SLEW_POS = 5;
    localparam int SM_INVERT_POS = 4;
    localparam int SM_STATE_POS = 3;
    localparam int SM_SOFT_POS = 0;
    localparam logic [7:0] SM_CTRL_RESET = 8'h20;
    localparam logic [7:0] SM_CTRL_WMASK = 8'hf1;
    localparam logic [1:0] SM_RESP_OKAY = 2'h0;
    localparam logic [1:0] SM_RESP_SLVERR = 2'h2;
endpackage : sm_pkg

// *** verilog/sm_mixer.sv ***
// carrier and modulator mixing with output polarity and drive gating
// assumes carrier and modulator inputs are synchronous to core_clk_in
`timescale 1ns/1ps
module sm_mixer (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic soft_bit_in,
    input wire logic soft_select_in,
    input wire logic invert_in,
    input wire logic drive_enable_in,
    input wire logic carrier_high_in,
    input wire logic carrier_low_in,
    input wire logic modulator_in,
    output logic pin_out,
    output logic state_out
);
    typedef struct packed {
        logic pin;
        logic state;
    } sm_mix_s;

    sm_mix_s st_r;
    sm_mix_s st_nxt;
    logic carh;
    logic carl;
    logic modv;
    logic mixed;

    ////////////////////////////////////////////////////////////////////////////////
    // no sleep input at all: sleep cannot touch this path
    always_comb begin
        carh = enable_in & carrier_high_in; // grounded while disabled
        carl = enable_in & carrier_low_in;
        // soft value is the source when disabled or selected
        modv = (!enable_in || soft_select_in) ? soft_bit_in : modulator_in;
        mixed = modv ? carh : carl;
        st_nxt.state = mixed ^ invert_in;
        st_nxt.pin = drive_enable_in & st_nxt.state; // low while undriven
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.pin;
    assign state_out = st_r.state;
endmodule : sm_mixer

// *** verilog/sm_top.sv ***
// signal modulator control: axi4-lite register slave plus mixer
// assumes sources are selected outside; soft_select_in flags the soft source
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module sm_top (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic carrier_high_in,
    input wire logic carrier_low_in,
    input wire logic modulator_in,
    input wire logic soft_select_in,
    output logic modulated_out,
    output logic pin_slew_limit_out,
    output logic module_active_out
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
    } sm_regs_s;

    sm_regs_s st_r;
    sm_regs_s st_nxt;
    logic state_bit;

    function automatic logic [7:0] sm_read_view(input logic [7:0] ctrl, input logic state);
        logic [7:0] v;
        v = ctrl & sm_pkg::SM_CTRL_WMASK; // bits 2:1 read zero
        v[sm_pkg::SM_STATE_POS] = state;
        return v;
    endfunction : sm_read_view

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // respond once both halves are in; one write in flight at a time
        if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            if (st_nxt.awaddr == sm_pkg::SM_CTRL_ADDR) begin
                st_nxt.bresp = sm_pkg::SM_RESP_OKAY;
                if (st_nxt.wstrb0) begin
                    // writes to bit 3 and bits 2:1 are dropped
                    st_nxt.ctrl = st_nxt.wdata & sm_pkg::SM_CTRL_WMASK;
                end
            end else begin
                st_nxt.bresp = sm_pkg::SM_RESP_SLVERR;
            end
        end
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            if (s_axi_araddr == sm_pkg::SM_CTRL_ADDR) begin
                st_nxt.rdata = {24'h00_0000, sm_read_view(st_r.ctrl, state_bit)};
                st_nxt.rresp = sm_pkg::SM_RESP_OKAY;
            end else begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rresp = sm_pkg::SM_RESP_SLVERR;
            end
        end
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.ctrl <= sm_pkg::SM_CTRL_RESET; // disabled, slew limit set
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state bit is one clock behind the inputs, so fast carriers may alias
    sm_mixer u_mixer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .enable_in(st_r.ctrl[sm_pkg::SM_ENABLE_POS]),
        .soft_bit_in(st_r.ctrl[sm_pkg::SM_SOFT_POS]),
        .soft_select_in(soft_select_in),
        .invert_in(st_r.ctrl[sm_pkg::SM_INVERT_POS]),
        .drive_enable_in(st_r.ctrl[sm_pkg::SM_OE_POS]),
        .carrier_high_in(carrier_high_in),
        .carrier_low_in(carrier_low_in),
        .modulator_in(modulator_in),
        .pin_out(modulated_out),
        .state_out(state_bit)
    );

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign pin_slew_limit_out = st_r.ctrl[sm_pkg::SM_SLEW_POS];
    assign module_active_out = st_r.ctrl[sm_pkg::SM_ENABLE_POS];
endmodule : sm_top

// *** tb/sm_src_model.sv ***
// source peripherals: carriers, modulator and source-select flag
// assumes the bench sets pat_in; outputs move on core_clk_in edges
`timescale 1ns/1ps
module sm_src_model (
    input wire logic core_clk_in,
    input wire logic [3:0] pat_in,
    output logic ch_out,
    output logic cl_out,
    output logic md_out,
    output logic ss_out
);
    always_ff @(posedge core_clk_in) begin
        {ch_out, cl_out, md_out} <= pat_in[3:1];
        ss_out <= pat_in[0];
    end
endmodule : sm_src_model

// *** tb/sm_top_sva.sv ***
// port assertions for sm_top
// assumes bound into sm_top, one clock, wstrb low lane always set
`timescale 1ns/1ps
module sm_top_sva (
    input wire logic core_clk_in, rst_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic modulated_out, pin_slew_limit_out, module_active_out,
    input wire logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_rdata
);
    logic go, dp;
    logic [1:0] sh_r;
    assign go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 32'h0;
    assign dp = sh_r[1] && sh_r[0];
    // shadow of drive enable and invert, only ports visible
    always_ff @(posedge core_clk_in) begin
        sh_r <= rst_in ? 2'h0 : go ? {s_axi_wdata[6], s_axi_wdata[4]} : sh_r;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    reset_defaults_a: assert property (disable iff (1'b0) rst_in |=>
        !module_active_out && pin_slew_limit_out && !modulated_out) else $error("reset state");
    enable_write_a: assert property (go |=>
        module_active_out == $past(s_axi_wdata[7])) else $error("enable not written");
    slew_write_a: assert property (go |=>
        pin_slew_limit_out == $past(s_axi_wdata[5])) else $error("slew not written");
    ctrl_hold_a: assert property (!go |=>
        $stable(module_active_out) && $stable(pin_slew_limit_out)) else $error("ctrl moved");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[2:1] == 2'h0)
        else $error("bad read answer");
    write_answer_a: assert property (go |=> s_axi_bvalid && !s_axi_awready)
        else $error("no write answer");
    pin_gated_a: assert property (!sh_r[1] |=> !modulated_out) else $error("pin driven");
    disabled_pin_a: assert property (!module_active_out |=>
        modulated_out == $past(dp)) else $error("disabled pin wrong");
endmodule : sm_top_sva
bind sm_top sm_top_sva chk_u (.core_clk_in, .rst_in, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .modulated_out, .pin_slew_limit_out, .module_active_out,
    .s_axi_awaddr, .s_axi_wdata, .s_axi_rdata);

// *** tb/test_sm_top.sv ***
// self-checking bench for sm_top over axi4-lite
// assumes sm_src_model drives the source inputs
`timescale 1ns/1ps
module test_sm_top;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd, d;
    logic [3:0] pat = 4'h0;
    logic [1:0] br, rr, r;
    logic awr, wrd, bv, arr, rv, mo, sl, ma, ch, cl, md, ss, m, st;
    int n_mismatch = 0, n_compared = 0;
    sm_top dut_u (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .carrier_high_in(ch),
        .carrier_low_in(cl), .modulator_in(md), .soft_select_in(ss), .modulated_out(mo),
        .pin_slew_limit_out(sl), .module_active_out(ma));
    sm_src_model src_u (.core_clk_in(clk), .pat_in(pat), .ch_out(ch), .cl_out(cl),
        .md_out(md), .ss_out(ss));
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task print_verdict;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // ready is registered, so its negedge value is what the next edge sees
    task acc(input logic w, input logic [31:0] a, v, output logic [31:0] q, output logic [1:0] p);
        logic ta, tw, tr, b;
        @(posedge clk);
        if (w) begin
            {awa, wd, awv, wv, bry} <= {a, v, 3'h7};
        end else begin
            {ara, arv, rry} <= {a, 2'h3};
        end
        do begin
            @(negedge clk);
            {ta, tw, tr} = {awr && awv, wrd && wv, arr && arv};
            {b, p, q} = w ? {bv, br, rd} : {rv, rr, rd};
            @(posedge clk);
            {awv, wv, arv} <= {awv && !ta, wv && !tw, arv && !tr};
        end while (!b);
        {bry, rry} <= 2'h0;
    endtask : acc
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, 32'h0, 32'h0, d, r);
        chk(d, {24'h0, sm_pkg::SM_CTRL_RESET});
        chk({29'h0, sl, ma, mo}, 32'h4); // slew set, inactive, pin low
        // bits 3:1 always written high: they must read back as state and zero
        for (int i = 0; i < 512; i++) begin
            pat <= i[3:0];
            acc(1'b1, 32'h0, {24'h0, i[8:5], 3'h7, i[4]}, d, r);
            repeat (2) @(negedge clk);
            m = (pat[0] || !i[8]) ? i[4] : pat[1];
            st = (i[8] && (m ? pat[3] : pat[2])) ^ i[5];
            chk({31'h0, mo}, {31'h0, i[7] & st});
            chk({31'h0, sl}, {31'h0, i[6]});
            chk({31'h0, ma}, {31'h0, i[8]});
            acc(1'b0, 32'h0, 32'h0, d, r);
            chk(d, {24'h0, i[8:5], st, 2'h0, i[4]});
        end
        acc(1'b1, 32'h4, 32'hff, d, r);
        chk({30'h0, r}, {30'h0, sm_pkg::SM_RESP_SLVERR});
        acc(1'b0, 32'h4, 32'h0, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, sm_pkg::SM_RESP_SLVERR});
        // refused write must leave the last good value; output state is zero here
        acc(1'b0, 32'h0, 32'h0, d, r);
        chk(d, 32'hf1);
        chk({30'h0, r}, {30'h0, sm_pkg::SM_RESP_OKAY});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, 32'h0, 32'h0, d, r);
        chk(d, {24'h0, sm_pkg::SM_CTRL_RESET});
        chk({29'h0, sl, ma, mo}, 32'h4); // mid-run reset disables the module
        print_verdict;
    end
    initial begin
        #200000;
        n_mismatch++;
        print_verdict;
    end
endmodule : test_sm_top
